// file: hw/isq_defs.svh
// isq_defs.svh: offsets, field positions, reset values and frame counts
// for the status and Q-channel block; included by hw/isq_status_q.sv only
`ifndef ISQ_DEFS_SVH
`define ISQ_DEFS_SVH

`define ISQ_OFF_STATUS 12'h000
`define ISQ_OFF_ENABLE 12'h004
`define ISQ_OFF_QTX 12'h008
`define ISQ_OFF_LINE 12'h00c
`define ISQ_OFF_CTRL 12'h010

`define ISQ_ST_MM 0
`define ISQ_ST_RICHG 1
`define ISQ_ST_QDONE 2
`define ISQ_ST_SS 3
`define ISQ_ST_TX_FRAME_FINISHED 4
`define ISQ_ST_TE 5
`define ISQ_ST_RF 6
`define ISQ_ST_RX_FRAME_END_FLAG 7

`define ISQ_Q_ENFLG 4
`define ISQ_Q_DONEQ 5
`define ISQ_LN_LIVE 2
`define ISQ_LN_CAPT 4
`define ISQ_CT_VOTE 0
`define ISQ_CT_MRES 1
`define ISQ_CT_RECEIVER_SOFT_RESET 2

`define ISQ_RST_BYTE 8'h00
`define ISQ_RST_NIB 4'h0
`define ISQ_RST_PAT 2'h0
`define ISQ_FRM_LAST 3'h4
`define ISQ_SLOT_LAST 2'h3
`define ISQ_SGRP_VOTE_LAST 3'h3
`define ISQ_SGRP_RAW_LAST 3'h4

`endif

// file: hw/isq_pkg.sv
// isq_pkg: types shared by the status and Q-channel block
// assumes nothing beyond a SystemVerilog compiler
package isq_pkg;
    typedef enum logic [0:0] {Q_IDLE, Q_SEND} isq_qstate_e;
    typedef logic [7:0] isq_byte_t;
endpackage

// file: hw/isq_status_q.sv
// isq_status_q: interrupt status, enables, line pattern and Q-channel
// transmit registers behind an APB slave.
// assumes event and level inputs come from framing/HDLC logic on pclk.
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "isq_defs.svh"

module isq_status_q
    import isq_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic [1:0] rx_pattern,
    input wire logic echo_bit_differs,
    input wire logic frame_tick,
    input wire logic multiframe_start,
    input wire logic multiframe_sync,
    input wire logic s_bit_tick,
    input wire logic tx_frame_finished,
    input wire logic tx_buffer_low_flag,
    input wire logic rx_buffer_high_flag,
    input wire logic rx_frame_end_flag,
    output logic q_bit,
    output logic q_bit_strobe
);

    isq_byte_t status;
    isq_byte_t enable;
    isq_byte_t set_vec;
    isq_byte_t clr_vec;
    isq_byte_t rd_mux;
    isq_qstate_e qstate;
    logic [3:0] qdata;
    logic [3:0] qshift;
    logic enflg;
    logic doneq;
    logic vote_mode;
    logic mres_pulse;
    logic receiver_soft_reset_pulse;
    logic rx_reset;
    logic [1:0] live_pattern;
    logic [1:0] captured_pattern;
    logic pat_chg;
    logic [2:0] frm;
    logic [1:0] slot;
    logic [2:0] s_cnt;
    logic [2:0] s_last;
    logic s_word_evt;
    logic q_load;
    logic q_done_evt;
    logic setup;
    logic access;
    logic wr;
    logic rd;
    logic hit_st;
    logic hit_en;
    logic hit_q;
    logic hit_ln;
    logic hit_ct;
    logic mapped;

    assign setup = psel & ~penable;
    assign access = psel & penable & pready;
    assign wr = access & pwrite & pstrb[0];
    assign rd = access & ~pwrite;
    assign hit_st = (paddr == ADDR_W'(`ISQ_OFF_STATUS));
    assign hit_en = (paddr == ADDR_W'(`ISQ_OFF_ENABLE));
    assign hit_q = (paddr == ADDR_W'(`ISQ_OFF_QTX));
    assign hit_ln = (paddr == ADDR_W'(`ISQ_OFF_LINE));
    assign hit_ct = (paddr == ADDR_W'(`ISQ_OFF_CTRL));
    assign mapped = hit_st | hit_en | hit_q | hit_ln | hit_ct;
    assign rx_reset = mres_pulse | receiver_soft_reset_pulse;
    assign pat_chg = (rx_pattern != live_pattern);
    assign s_last = vote_mode ? `ISQ_SGRP_VOTE_LAST : `ISQ_SGRP_RAW_LAST;
    // a word only counts while multiframe sync holds
    assign s_word_evt = multiframe_sync & s_bit_tick & (s_cnt == s_last);
    assign q_load = multiframe_start & enflg;
    assign q_done_evt = multiframe_start & (qstate == Q_SEND);

    always_comb begin
        rd_mux = `ISQ_RST_BYTE;
        if (hit_st) begin
            rd_mux = status;
        end else if (hit_en) begin
            rd_mux = enable;
        end else if (hit_q) begin
            rd_mux[3:0] = qdata;
            rd_mux[`ISQ_Q_ENFLG] = enflg;
            rd_mux[`ISQ_Q_DONEQ] = doneq;
        end else if (hit_ln) begin
            rd_mux[`ISQ_LN_LIVE+:2] = live_pattern;
            rd_mux[`ISQ_LN_CAPT+:2] = captured_pattern;
        end else if (hit_ct) begin
            rd_mux[`ISQ_CT_VOTE] = vote_mode;
        end
    end

    // answer in the cycle after setup; data snapshot taken at setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup) begin
            pready <= 1'b1;
            prdata <= {24'h00_0000, rd_mux};
            pslverr <= ~mapped;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    always_comb begin
        set_vec = `ISQ_RST_BYTE;
        set_vec[`ISQ_ST_MM] = echo_bit_differs;
        set_vec[`ISQ_ST_RICHG] = pat_chg;
        set_vec[`ISQ_ST_QDONE] = q_done_evt;
        set_vec[`ISQ_ST_SS] = s_word_evt;
        set_vec[`ISQ_ST_TX_FRAME_FINISHED] = tx_frame_finished;
        set_vec[`ISQ_ST_TE] = tx_buffer_low_flag;
        set_vec[`ISQ_ST_RF] = rx_buffer_high_flag;
        set_vec[`ISQ_ST_RX_FRAME_END_FLAG] = rx_frame_end_flag;
        clr_vec = `ISQ_RST_BYTE;
        // a read clears only the bits the host actually saw, so a late event survives
        if (rd && hit_st) begin
            clr_vec = prdata[7:0];
        end
        if (wr && hit_st) begin
            clr_vec = clr_vec | pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= `ISQ_RST_BYTE;
        end else begin
            status <= (status & ~clr_vec) | set_vec;
            // receiver reset beats a coincident end-of-frame
            if (rx_reset) begin
                status[`ISQ_ST_RX_FRAME_END_FLAG] <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable <= `ISQ_RST_BYTE;
        end else if (wr && hit_en) begin
            enable <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status & enable);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vote_mode <= 1'b0;
            mres_pulse <= 1'b0;
            receiver_soft_reset_pulse <= 1'b0;
        end else begin
            mres_pulse <= wr & hit_ct & pwdata[`ISQ_CT_MRES];
            receiver_soft_reset_pulse <= wr & hit_ct & pwdata[`ISQ_CT_RECEIVER_SOFT_RESET];
            if (wr && hit_ct) begin
                vote_mode <= pwdata[`ISQ_CT_VOTE];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            live_pattern <= `ISQ_RST_PAT;
            captured_pattern <= `ISQ_RST_PAT;
        end else begin
            live_pattern <= rx_pattern;
            if (pat_chg) begin
                captured_pattern <= rx_pattern;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_cnt <= 3'h0;
        end else if (!multiframe_sync || rx_reset) begin
            s_cnt <= 3'h0;
        end else if (s_bit_tick) begin
            s_cnt <= (s_cnt == s_last) ? 3'h0 : s_cnt + 3'h1;
        end
    end

    // writes while a nibble is pending are dropped so the pending one survives
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            qdata <= `ISQ_RST_NIB;
            enflg <= 1'b0;
            doneq <= 1'b0;
        end else begin
            if (q_load) begin
                enflg <= 1'b0;
            end else if (wr && hit_q && !enflg) begin
                qdata <= pwdata[3:0];
                enflg <= pwdata[`ISQ_Q_ENFLG];
            end
            if (q_done_evt) begin
                doneq <= 1'b1;
            end else if (wr && hit_q && !enflg && pwdata[`ISQ_Q_ENFLG]) begin
                doneq <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            qstate <= Q_IDLE;
            qshift <= `ISQ_RST_NIB;
            frm <= 3'h0;
            slot <= 2'h0;
            q_bit <= 1'b1;
            q_bit_strobe <= 1'b0;
        end else begin
            q_bit_strobe <= 1'b0;
            if (multiframe_start) begin
                frm <= 3'h0;
                slot <= 2'h0;
                if (enflg) begin
                    qstate <= Q_SEND;
                    qshift <= qdata;
                    q_bit <= qdata[0];
                    q_bit_strobe <= 1'b1;
                end else begin
                    qstate <= Q_IDLE;
                    q_bit <= 1'b1;
                end
            end else if (frame_tick && qstate == Q_SEND) begin
                if (frm == `ISQ_FRM_LAST) begin
                    frm <= 3'h0;
                    if (slot != `ISQ_SLOT_LAST) begin
                        slot <= slot + 2'h1;
                        q_bit <= qshift[slot + 2'h1];
                        q_bit_strobe <= 1'b1;
                    end
                end else begin
                    frm <= frm + 3'h1;
                end
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_status_read;
        psel && penable && pready && !pwrite && hit_st;
    endsequence

    property p_pat_capture;
        pat_chg |=> status[`ISQ_ST_RICHG] && captured_pattern == $past(rx_pattern);
    endproperty
    a_pat_capture: assert property (p_pat_capture)
        else $error("pattern change not captured");

    property p_live;
        ##1 1'b1 |-> ##1 live_pattern == $past(rx_pattern, 1);
    endproperty
    a_live: assert property (p_live)
        else $error("live pattern lags input");

    property p_read_clear;
        s_status_read ##0 prdata[`ISQ_ST_RICHG] && !pat_chg |=> !status[`ISQ_ST_RICHG];
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("changed flag not cleared");

    property p_irq;
        ##1 1'b1 |-> irq == $past(|(status & enable));
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt does not follow enabled flags");

    property p_qdone;
        q_done_evt |=> status[`ISQ_ST_QDONE] && doneq;
    endproperty
    a_qdone: assert property (p_qdone)
        else $error("q done not flagged");

    property p_sword_set;
        s_word_evt |=> status[`ISQ_ST_SS];
    endproperty
    a_sword_set: assert property (p_sword_set)
        else $error("s word not flagged");

    property p_no_sync_ss;
        !multiframe_sync && !status[`ISQ_ST_SS] |=> !status[`ISQ_ST_SS];
    endproperty
    a_no_sync_ss: assert property (p_no_sync_ss)
        else $error("s word flagged without sync");

    property p_tx_frame_finished_set;
        tx_frame_finished |=> status[`ISQ_ST_TX_FRAME_FINISHED];
    endproperty
    a_tx_frame_finished_set: assert property (p_tx_frame_finished_set)
        else $error("tx done not flagged");

    property p_tx_frame_finished_clr;
        s_status_read ##0 prdata[`ISQ_ST_TX_FRAME_FINISHED] && !tx_frame_finished
            |=> !status[`ISQ_ST_TX_FRAME_FINISHED];
    endproperty
    a_tx_frame_finished_clr: assert property (p_tx_frame_finished_clr)
        else $error("tx done not cleared by read");

    property p_te_set;
        tx_buffer_low_flag |=> status[`ISQ_ST_TE];
    endproperty
    a_te_set: assert property (p_te_set)
        else $error("tx empty not flagged");

    property p_rx_frame_end_flag_set;
        rx_frame_end_flag && !rx_reset |=> status[`ISQ_ST_RX_FRAME_END_FLAG];
    endproperty
    a_rx_frame_end_flag_set: assert property (p_rx_frame_end_flag_set)
        else $error("rx end not flagged");

    property p_rx_frame_end_flag_reset;
        rx_reset |=> !status[`ISQ_ST_RX_FRAME_END_FLAG];
    endproperty
    a_rx_frame_end_flag_reset: assert property (p_rx_frame_end_flag_reset)
        else $error("rx end not cleared by reset");

    property p_q_first;
        q_load |=> q_bit_strobe && q_bit == $past(qdata[0]) && slot == 2'h0;
    endproperty
    a_q_first: assert property (p_q_first)
        else $error("first q bit wrong");

    property p_enflg;
        q_load |=> !enflg;
    endproperty
    a_enflg: assert property (p_enflg)
        else $error("enable flag not released");

    property p_echo;
        echo_bit_differs |=> status[`ISQ_ST_MM];
    endproperty
    a_echo: assert property (p_echo)
        else $error("mismatch not flagged");

    property p_doneq_hold;
        doneq && !(psel && pwrite && hit_q) |=> doneq;
    endproperty
    a_doneq_hold: assert property (p_doneq_hold)
        else $error("q sent bit dropped without a new load");

endmodule

// file: testbench/isq_nt_model.sv
// isq_nt_model: line-side frame timing and Q-bit collector for isq_status_q
// assumes frame timing on pclk; multiframe_start replaces the tick of frame 0
`timescale 1ns/1ps

module isq_nt_model #(
    parameter int FRAME_CYC = 6
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic q_bit,
    input wire logic q_bit_strobe,
    output logic frame_tick,
    output logic multiframe_start,
    output logic [3:0] nib,
    output logic [2:0] nbits,
    output logic gap_err
);
    int cyc;
    int frm;
    logic [2:0] gap;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc <= 0;
            frm <= 0;
            frame_tick <= 1'b0;
            multiframe_start <= 1'b0;
        end else begin
            frame_tick <= 1'b0;
            multiframe_start <= 1'b0;
            if (cyc == FRAME_CYC - 1) begin
                cyc <= 0;
                frm <= (frm == 19) ? 0 : frm + 1;
                if (frm == 19) begin
                    multiframe_start <= 1'b1;
                end else begin
                    frame_tick <= 1'b1;
                end
            end else begin
                cyc <= cyc + 1;
            end
        end
    end

    // first strobe of a nibble lands at frame 0, the rest five frames apart
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nib <= 4'h0;
            nbits <= 3'h0;
            gap <= 3'h0;
            gap_err <= 1'b0;
        end else begin
            if (frame_tick || multiframe_start) begin
                gap <= gap + 3'h1;
            end
            if (q_bit_strobe) begin
                nib[nbits[1:0]] <= q_bit;
                nbits <= nbits + 3'h1;
                gap <= 3'h0;
                if (nbits[1:0] != 2'h0 && gap != 3'h5) begin
                    gap_err <= 1'b1;
                end
            end
        end
    end
endmodule

// file: testbench/tb.sv
// tb: self-checking bench for isq_status_q over APB
// assumes an APB slave that answers in its own time and the isq_nt_model frame source
`timescale 1ns/1ps

module tb;
    import isq_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, irq, q_bit, q_bit_strobe, frame_tick, multiframe_start, gap_err;
    logic [1:0] rx_pattern = 2'h0;
    logic [7:0] ev = 8'h00;
    logic multiframe_sync = 1'b0;
    logic s_bit_tick = 1'b0;
    logic [3:0] nib;
    logic [2:0] nbits;
    logic [31:0] rd;
    logic er;
    int error_cnt = 0;
    int samples_checked = 0;
    int cyc = 0;
    int bl[5] = '{0, 4, 5, 6, 7};

    always #2.5 pclk = ~pclk;

    isq_status_q i_isq_status_q(.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .rx_pattern(rx_pattern), .echo_bit_differs(ev[0]), .frame_tick(frame_tick),
        .multiframe_start(multiframe_start), .multiframe_sync(multiframe_sync),
        .s_bit_tick(s_bit_tick), .tx_frame_finished(ev[4]), .tx_buffer_low_flag(ev[5]),
        .rx_buffer_high_flag(ev[6]), .rx_frame_end_flag(ev[7]), .q_bit(q_bit),
        .q_bit_strobe(q_bit_strobe));

    isq_nt_model i_isq_nt_model(.pclk(pclk), .presetn(presetn), .q_bit(q_bit),
        .q_bit_strobe(q_bit_strobe), .frame_tick(frame_tick),
        .multiframe_start(multiframe_start), .nib(nib), .nbits(nbits), .gap_err(gap_err));

    task results;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // entered just after a rising edge; leaves one idle cycle so psel is never set twice
    // pready and read data are taken at the rising edge that completes the access
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp,
             input string nm);
        xfer(1'b0, a, 32'h0);
        chk(nm, exp, rd & m);
    endtask

    task idle(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task pulse(input logic [7:0] b);
        ev <= b;
        @(posedge pclk);
        ev <= 8'h00;
        idle(2);
    endtask

    task sp(input int n);
        repeat (n) begin
            s_bit_tick <= 1'b1;
            @(posedge pclk);
            s_bit_tick <= 1'b0;
            @(posedge pclk);
        end
        idle(1);
    endtask

    // a missing multiframe is caught by the cycle ceiling
    task wms;
        while (multiframe_start !== 1'b1) begin
            @(posedge pclk);
        end
        @(posedge pclk);
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            results;
        end
    end

    initial begin
        idle(6);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc(12'h000, 32'hffffffff, 32'h0, "status reset");
        rdc(12'h004, 32'hffffffff, 32'h0, "enable reset");
        rdc(12'h008, 32'hff, 32'h0, "q reset");
        xfer(1'b0, 12'h020, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rd);
        foreach (bl[i]) begin
            pulse(8'h01 << bl[i]);
            rdc(12'h000, 32'hff, 32'h1 << bl[i], "flag set");
            rdc(12'h000, 32'hff, 32'h0, "flag cleared");
        end
        pulse(8'h01);
        xfer(1'b1, 12'h000, 32'h01);
        rdc(12'h000, 32'hff, 32'h0, "flag write one clear");
        pulse(8'h10);
        chk("irq masked", 32'h0, {31'h0, irq});
        xfer(1'b1, 12'h004, 32'h10);
        idle(2);
        chk("irq enabled", 32'h1, {31'h0, irq});
        xfer(1'b1, 12'h004, 32'hff);
        rdc(12'h000, 32'hff, 32'h10, "tx done");
        idle(2);
        chk("irq cleared", 32'h0, {31'h0, irq});
        rx_pattern <= 2'h2;
        idle(3);
        rdc(12'h00c, 32'h3c, 32'h28, "line");
        rx_pattern <= 2'h1;
        idle(3);
        rdc(12'h00c, 32'h0c, 32'h04, "live");
        rdc(12'h000, 32'h02, 32'h02, "changed");
        rdc(12'h000, 32'h02, 32'h0, "changed clr");
        xfer(1'b1, 12'h010, 32'h02);
        sp(5);
        rdc(12'h000, 32'h08, 32'h0, "s word no sync");
        multiframe_sync <= 1'b1;
        xfer(1'b1, 12'h010, 32'h02);
        sp(4);
        rdc(12'h000, 32'h08, 32'h0, "s word 4 raw");
        sp(1);
        rdc(12'h000, 32'h08, 32'h08, "s word 5 raw");
        xfer(1'b1, 12'h010, 32'h01);
        sp(3);
        rdc(12'h000, 32'h08, 32'h0, "s word 3 vote");
        sp(1);
        rdc(12'h000, 32'h08, 32'h08, "s word 4 vote");
        for (int k = 1; k < 3; k++) begin
            pulse(8'h80);
            xfer(1'b1, 12'h010, 32'h1 << k);
            rdc(12'h000, 32'h80, 32'h0, "rx end reset");
        end
        wms;
        xfer(1'b1, 12'h008, 32'h1b);
        xfer(1'b1, 12'h008, 32'h15);
        rdc(12'h008, 32'h1f, 32'h1b, "q loaded");
        while (nbits !== 3'h4) begin
            @(posedge pclk);
        end
        wms;
        idle(3);
        chk("q nibble", 32'hb, {28'h0, nib});
        chk("q spacing", 32'h0, {31'h0, gap_err});
        rdc(12'h000, 32'h04, 32'h04, "q done");
        rdc(12'h008, 32'h30, 32'h20, "q sent");
        xfer(1'b1, 12'h008, 32'h15);
        rdc(12'h008, 32'h30, 32'h10, "q sent clr");
        results;
    end
endmodule
